// ---- hw/mcl_defs.svh ----
`ifndef MCL_DEFS_SVH
`define MCL_DEFS_SVH

// Clock period and millisecond length, in ns
`define MCL_CLK_NS      20
`define MCL_MS_NS       1000000
// Cycles per millisecond tick
`define MCL_CYC_PER_MS  (`MCL_MS_NS / `MCL_CLK_NS)
`define MCL_PRE_W       16

// Carrier detect qualify and guard times, ms
`define MCL_DCD_ON_MS   6'h28
`define MCL_DCD_OFF_MS  6'h0f
`define MCL_DCD_CNT_W   6

// Request-to-send to clear-to-send delay, ms
`define MCL_CTS_MS      8'hc8
`define MCL_CTS_CNT_W   8

// Bit positions of the synchronised terminal leads
`define MCL_LEAD_DTR    0
`define MCL_LEAD_RTS    1
`define MCL_LEAD_TD     2
`define MCL_LEAD_SA     3
`define MCL_LEAD_N      4

// Idle level of a data lead: marking, binary one
`define MCL_MARK        1'h1

`endif

// ---- hw/mcl_pkg.sv ----
`include "mcl_defs.svh"

package mcl_pkg;

  typedef enum logic [1:0]
  {
    MCL_ON_HOOK = 2'b00,
    MCL_DATA    = 2'b01,
    MCL_VOICE   = 2'b10
  } mcl_conn_type;

  typedef struct packed
  {
    logic [`MCL_LEAD_N-1:0]    sync1;
    logic [`MCL_LEAD_N-1:0]    sync2;
    logic [`MCL_PRE_W-1:0]     pre;
    logic                      tick;
    mcl_conn_type              conn;
    logic [`MCL_CTS_CNT_W-1:0] cts_cnt;
    logic                      dsr;
    logic                      cts;
    logic                      dcd;
    logic                      ri;
    logic                      rd;
    logic                      sb;
    logic                      off_hook;
    logic                      tx_data;
    logic                      tx_carrier;
    logic                      rev_tx;
  } mcl_top_state_type;

  typedef struct packed
  {
    logic [`MCL_DCD_CNT_W-1:0] on_cnt;
    logic [`MCL_DCD_CNT_W-1:0] off_cnt;
    logic                      dcd;
  } mcl_cd_state_type;

endpackage

// ---- hw/mcl_cd_if.sv ----
`timescale 1ns/10ps

interface mcl_cd_if;
  logic ms_tick;
  logic carrier;
  logic dcd;

  modport ctl
  (
    output ms_tick,
    output carrier,
    input  dcd
  );

  modport det
  (
    input  ms_tick,
    input  carrier,
    output dcd
  );
endinterface

// ---- hw/mcl_carrier_det.sv ----
`timescale 1ns/10ps
`include "mcl_defs.svh"

module mcl_carrier_det
#(
  parameter logic [`MCL_DCD_CNT_W-1:0] ON_MS  = `MCL_DCD_ON_MS,
  parameter logic [`MCL_DCD_CNT_W-1:0] OFF_MS = `MCL_DCD_OFF_MS
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  mcl_cd_if.det    cd
);

  mcl_pkg::mcl_cd_state_type r;
  mcl_pkg::mcl_cd_state_type next_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Qualify and guard counters, both in whole ms ticks
  always_comb
  begin
    next_r = r;
    if (!cd.carrier)
    begin
      // Any gap restarts qualification, so carrier must be continuous
      next_r.on_cnt = '0;
      // R10: guard before drop
      if (r.dcd && cd.ms_tick)
      begin
        if (r.off_cnt == OFF_MS - 1'h1)
        begin
          next_r.dcd     = 1'h0;
          next_r.off_cnt = '0;
        end
        else
          next_r.off_cnt = r.off_cnt + 1'h1;
      end
    end
    else
    begin
      // A short fade inside the guard leaves detect on
      next_r.off_cnt = '0;
      // R9: continuous carrier qualify
      if (!r.dcd && cd.ms_tick)
      begin
        if (r.on_cnt == ON_MS - 1'h1)
        begin
          next_r.dcd    = 1'h1;
          next_r.on_cnt = '0;
        end
        else
          next_r.on_cnt = r.on_cnt + 1'h1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign cd.dcd = r.dcd;

  // R9: rise only after full count
  a_dcd_rise_count: assert property ( // R9
    $rose(r.dcd) |-> $past(r.on_cnt) == ON_MS - 1'h1 && $past(cd.carrier) && $past(cd.ms_tick))
    else $error("carrier detect rose before qualify time");

  // R10: fall only after guard
  a_dcd_fall_guard: assert property ( // R10
    $fell(r.dcd) |-> $past(r.off_cnt) == OFF_MS - 1'h1 && !$past(cd.carrier))
    else $error("carrier detect fell without guard delay");

  // R10: carrier present keeps detect on
  a_dcd_hold_on: assert property ( // R10
    (r.dcd && cd.carrier) |=> r.dcd)
    else $error("carrier detect dropped while carrier present");

endmodule

// ---- hw/mcl_lead_ctrl.sv ----
// Contract
// R1: Data set ready off when faulted, in voice, or on hook; on otherwise.
// R2: Terminal must not read data set ready as remote channel status.
// R3: Terminal ready permits connection; origination-only merely holds external connection.
// R4: Auto-answer station connects to line on incoming ringing.
// R5: Terminal ready off disconnects and goes on hook.
// R6: Ring indicator works regardless of terminal ready.
// R7: Manual answer drops call if terminal ready off at data key.
// R8: Ring indicator on while ringing received, off otherwise.
// R9: Carrier detect on only after 40 ms continuous carrier.
// R10: Carrier detect off 15 ms after carrier loss.
// R11: Half duplex detector responds to local or remote carrier.
// R12: Terminal sends supervisory data only while request to send off.
// R13: Supervisory receive lead carries reverse channel data alongside main data.
// R14: Data leads: one is marking, zero is spacing.
// R15: Data leads held marking when no data sent.
// R16: Control leads: positive level on, negative level off.
// R17: Terminal may use request to send and ready for fail-safe checks.
// R18: Clear to send off whenever request to send off.
// R19: Unattended terminal drops ready after 30 s without carrier.
// R20: Incoming leads double-synchronised; ms delays from clock prescaler.

`timescale 1ns/10ps
`include "mcl_defs.svh"

module mcl_lead_ctrl
#(
  parameter int unsigned                CYC_PER_MS  = `MCL_CYC_PER_MS,
  parameter logic [`MCL_CTS_CNT_W-1:0]  CTS_MS      = `MCL_CTS_MS,
  parameter logic                       REV_CHANNEL = 1'h1
)
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic dtr,
  input  wire logic rts,
  input  wire logic td,
  input  wire logic sa,
  output logic      dsr,
  output logic      cts,
  output logic      dcd,
  output logic      ri,
  output logic      rd,
  output logic      sb,
  input  wire logic ring_detect,
  input  wire logic line_carrier,
  input  wire logic demod_data,
  input  wire logic rev_rx_data,
  input  wire logic ext_connect,
  input  wire logic handset_off_hook,
  input  wire logic data_key,
  input  wire logic fault,
  input  wire logic auto_answer,
  input  wire logic origin_only,
  input  wire logic half_duplex,
  output logic      off_hook,
  output logic      tx_data,
  output logic      tx_carrier,
  output logic      rev_tx_data
);

  mcl_pkg::mcl_top_state_type r;
  mcl_pkg::mcl_top_state_type next_r;
  logic                       dtr_on;
  logic                       rts_on;

  mcl_cd_if cd_bus ();

  // Data-mode decode, shared by several leads and checks
  function automatic logic in_data(input mcl_pkg::mcl_conn_type conn);
    in_data = conn == mcl_pkg::MCL_DATA;
  endfunction

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Control leads are logic one for on (positive level)
  // R16: control polarity
  assign dtr_on = r.sync2[`MCL_LEAD_DTR];
  assign rts_on = r.sync2[`MCL_LEAD_RTS];

  always_comb
  begin
    next_r = r;

    // R20: two-stage lead synchroniser
    next_r.sync1 = {sa, td, rts, dtr};
    next_r.sync2 = r.sync1;

    // R20: millisecond prescaler
    next_r.tick = 1'h0;
    if (r.pre == `MCL_PRE_W'(CYC_PER_MS - 1))
    begin
      next_r.pre  = '0;
      next_r.tick = 1'h1;
    end
    else
      next_r.pre = r.pre + 1'h1;

    // Line connection state
    case (r.conn)
      mcl_pkg::MCL_ON_HOOK:
      begin
        // R4: answer on ringing
        if (auto_answer && !origin_only && ring_detect && dtr_on)
          next_r.conn = mcl_pkg::MCL_DATA;
        // R3: hold external connection
        else if (ext_connect && dtr_on)
          next_r.conn = mcl_pkg::MCL_DATA;
        else if (handset_off_hook)
          next_r.conn = mcl_pkg::MCL_VOICE;
      end
      mcl_pkg::MCL_VOICE:
      begin
        // R7: data key needs terminal ready
        if (data_key)
          next_r.conn = dtr_on ? mcl_pkg::MCL_DATA : mcl_pkg::MCL_ON_HOOK;
        else if (!handset_off_hook)
          next_r.conn = mcl_pkg::MCL_ON_HOOK;
      end
      mcl_pkg::MCL_DATA:
      begin
        // R5: hang up on ready off
        if (!dtr_on)
          next_r.conn = mcl_pkg::MCL_ON_HOOK;
      end
      default:
        next_r.conn = mcl_pkg::MCL_ON_HOOK;
    endcase
    next_r.off_hook = next_r.conn != mcl_pkg::MCL_ON_HOOK;

    // R1: ready only when connected and sound
    next_r.dsr = in_data(next_r.conn) && !fault;

    // R8: ring follows ringing, R6: terminal ready ignored here
    next_r.ri = ring_detect;

    // Carrier goes out while request to send is on
    next_r.tx_carrier = in_data(r.conn) && rts_on;

    // R18: clear to send tracks request
    if (!rts_on || !in_data(r.conn))
    begin
      next_r.cts     = 1'h0;
      next_r.cts_cnt = '0;
    end
    else if (r.tick && !r.cts)
    begin
      if (r.cts_cnt == CTS_MS - 1'h1)
        next_r.cts = 1'h1;
      else
        next_r.cts_cnt = r.cts_cnt + 1'h1;
    end

    // R15: modulator idles marking
    next_r.tx_data = (r.tx_carrier && r.cts) ? r.sync2[`MCL_LEAD_TD] : `MCL_MARK;

    // Registered copy keeps the output straight from a flop
    next_r.dcd = cd_bus.dcd;

    // R14: received one stays marking
    next_r.rd = r.dcd ? demod_data : `MCL_MARK;

    // R13: reverse channel receive
    next_r.sb = (REV_CHANNEL && r.dsr) ? rev_rx_data : `MCL_MARK;

    // R12: supervisory send is the terminal's duty; idle mark otherwise
    next_r.rev_tx = (REV_CHANNEL && in_data(r.conn) && !rts_on)
                    ? r.sync2[`MCL_LEAD_SA] : `MCL_MARK;
  end

  // State register; data leads come out of reset marking
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      r         <= '0;
      r.rd      <= `MCL_MARK;
      r.sb      <= `MCL_MARK;
      r.tx_data <= `MCL_MARK;
      r.rev_tx  <= `MCL_MARK;
    end
    else
      r <= next_r;
  end

  // R11: local carrier counts in half duplex
  assign cd_bus.ms_tick = r.tick;
  assign cd_bus.carrier = in_data(r.conn)
                          && (line_carrier || (half_duplex && r.tx_carrier));

  mcl_carrier_det u_carrier_det
  (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .cd      (cd_bus.det)
  );

  assign dsr         = r.dsr;
  assign cts         = r.cts;
  assign dcd         = r.dcd;
  assign ri          = r.ri;
  assign rd          = r.rd;
  assign sb          = r.sb;
  assign off_hook    = r.off_hook;
  assign tx_data     = r.tx_data;
  assign tx_carrier  = r.tx_carrier;
  assign rev_tx_data = r.rev_tx;

  // R1: no ready while on hook or voice
  a_dsr_needs_data: assert property ( // R1
    (r.conn != mcl_pkg::MCL_DATA || $past(fault)) |-> !dsr)
    else $error("data set ready on while not in usable data mode");

  // R5: ready off hangs up
  a_dtr_hang_up: assert property ( // R5
    (r.conn == mcl_pkg::MCL_DATA && !dtr_on) |=> !off_hook ##1 !dsr)
    else $error("call held after terminal ready went off");

  // R4: ringing answered
  a_ring_answer: assert property ( // R4
    (r.conn == mcl_pkg::MCL_ON_HOOK && auto_answer && !origin_only
     && ring_detect && dtr_on) |=> off_hook && r.conn == mcl_pkg::MCL_DATA)
    else $error("auto-answer station did not answer ringing");

  // R7: manual answer drop
  a_data_key_drop: assert property ( // R7
    (r.conn == mcl_pkg::MCL_VOICE && data_key && !dtr_on) |=> !off_hook)
    else $error("manual call kept with terminal ready off");

  // R6: ring indication with ready off
  a_ring_no_dtr: assert property ( // R6
    (ring_detect && !dtr_on) |=> ri)
    else $error("ring indicator blocked by terminal ready off");

  // R18: clear to send follows request off
  a_cts_follow_rts: assert property ( // R18
    !rts_on |=> !cts)
    else $error("clear to send on while request to send off");

  // R15: no carrier keeps receive marking
  a_rd_idle_mark: assert property ( // R15
    !$past(dcd) |-> rd)
    else $error("received data not marking without carrier");

  // R13: supervisory lead carries reverse data
  a_sb_reverse: assert property ( // R13
    ($past(dsr) && REV_CHANNEL) |-> sb == $past(rev_rx_data))
    else $error("supervisory receive lead does not follow reverse channel");

  // R20: tick is a single-cycle pulse
  a_tick_pulse: assert property ( // R20
    r.tick |=> !r.tick ##1 !r.tick)
    else $error("millisecond tick longer than one cycle");

  // R1: ready on in a sound data call
  a_dsr_on_data: assert property ( // R1
    (in_data(r.conn) && dtr_on && !fault) |=> dsr)
    else $error("data set ready off in a sound data call");

  // R3: external connection held
  a_ext_connect: assert property ( // R3
    (r.conn == mcl_pkg::MCL_ON_HOOK && ext_connect && dtr_on) |=> in_data(r.conn))
    else $error("external connection not taken with terminal ready on");

  // R3: no data call without ready
  a_no_call_unready: assert property ( // R3
    (r.conn == mcl_pkg::MCL_ON_HOOK && !dtr_on) |=> !in_data(r.conn))
    else $error("data call set up with terminal ready off");

  // R3: origination-only ignores ringing
  a_origin_no_answer: assert property ( // R3
    (r.conn == mcl_pkg::MCL_ON_HOOK && origin_only && !ext_connect) |=> !in_data(r.conn))
    else $error("origination-only station answered ringing");

  // R8: ring indicator tracks ringing
  a_ri_track: assert property ( // R8
    $past(resetn) |-> ri == $past(ring_detect))
    else $error("ring indicator does not follow ringing");

  // R15: transmit idles marking without clear to send
  a_tx_idle_mark: assert property ( // R15
    !$past(cts) |-> tx_data)
    else $error("transmit data not marking while clear to send off");

  // R14: transmit passes terminal data bit for bit
  a_tx_data_pass: assert property ( // R14
    ($past(resetn) && $past(r.tx_carrier) && $past(r.cts))
    |-> tx_data == $past(r.sync2[`MCL_LEAD_TD]))
    else $error("transmit data differs from terminal data");

  // R11: own carrier keeps detect from dropping in half duplex
  a_local_carrier: assert property ( // R11
    (in_data(r.conn) && half_duplex && r.tx_carrier) |=> !$fell(cd_bus.dcd))
    else $error("carrier detect dropped with local carrier in half duplex");

  // R18: clear to send only in a data call
  a_cts_in_data: assert property ( // R18
    !in_data(r.conn) |=> !cts)
    else $error("clear to send on outside a data call");

  // R13: supervisory lead marks while not ready
  a_sb_idle_mark: assert property ( // R13
    !$past(dsr) |-> sb)
    else $error("supervisory receive lead not marking while not ready");

endmodule

// ---- verification/mcl_term_model.sv ----
`timescale 1ns/10ps

module mcl_term_model
#(
  parameter int unsigned QUIET_CYC = 3000
)
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic ready_req,
  input  wire logic send_req,
  input  wire logic tx_bit,
  input  wire logic sup_bit,
  input  wire logic dsr,
  input  wire logic cts,
  input  wire logic dcd,
  output logic      dtr,
  output logic      rts,
  output logic      td,
  output logic      sa
);
  int unsigned quiet;
  logic        heard;
  logic [2:0]  stat_s1;
  logic [2:0]  stat_s2;

  // status leads pass two flops before the terminal acts on them
  always_ff @(posedge sys_clk)
  begin
    stat_s1 <= {dcd, cts, dsr};
    stat_s2 <= stat_s1;
  end

  // ready status only times a silent call, never reads as remote
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !ready_req)
    begin
      quiet <= 0;
      heard <= 1'h0;
    end
    else if (stat_s2[0])
    begin
      heard <= heard | stat_s2[2];
      if (!heard && !stat_s2[2] && quiet < QUIET_CYC)
        quiet <= quiet + 1;
    end
  end

  // one is mark, idle mark, supervisory only with send off
  always_ff @(posedge sys_clk)
  begin
    dtr <= resetn & ready_req & (quiet < QUIET_CYC);
    rts <= resetn & send_req;
    td  <= (resetn & send_req & stat_s2[1]) ? tx_bit : 1'h1;
    sa  <= (resetn & !send_req) ? sup_bit : 1'h1;
  end
endmodule

// ---- verification/mcl_lead_ctrl_tb.sv ----
`timescale 1ns/10ps

module mcl_lead_ctrl_tb;
  typedef struct packed
  {
    logic fault, ring, aa, oo, ext, hs, rdy;
    logic e_dsr, e_hook, e_ri;
  } mcl_row_type;

  logic sys_clk, resetn, ring, aa, oo, ext, hs, key, fault, hd, carrier, demod;
  logic rev_rx, rdy, snd, txb, supb;
  logic dtr, rts, td, sa, dsr, cts, dcd, ri, rd, sb, hook, txd, txc, rtx;
  int   miscompares;
  int   tests_run;
  mcl_row_type rows [11];

  // Scaled ms so the 40 ms qualify takes 400 cycles
  mcl_lead_ctrl #(.CYC_PER_MS(10), .CTS_MS(8'h04), .REV_CHANNEL(1'h1)) dut
  (
    .sys_clk(sys_clk), .resetn(resetn), .dtr(dtr), .rts(rts), .td(td), .sa(sa),
    .dsr(dsr), .cts(cts), .dcd(dcd), .ri(ri), .rd(rd), .sb(sb),
    .ring_detect(ring), .line_carrier(carrier), .demod_data(demod),
    .rev_rx_data(rev_rx), .ext_connect(ext), .handset_off_hook(hs), .data_key(key),
    .fault(fault), .auto_answer(aa), .origin_only(oo), .half_duplex(hd),
    .off_hook(hook), .tx_data(txd), .tx_carrier(txc), .rev_tx_data(rtx)
  );

  mcl_term_model term
  (
    .sys_clk(sys_clk), .resetn(resetn), .ready_req(rdy), .send_req(snd),
    .tx_bit(txb), .sup_bit(supb), .dsr(dsr), .cts(cts), .dcd(dcd),
    .dtr(dtr), .rts(rts), .td(td), .sa(sa)
  );

  // Clock
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Watchdog, well past the expected 1552 cycles
  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_rst(input logic [9:0] got);
    tests_run++;
    if (got !== 10'h00f)
    begin
      miscompares++;
      $display("mismatch reset outputs expected %h seen %h", 10'h00f, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: rows walk the connection states, then timed cases
  initial
  begin
    miscompares = 0;
    tests_run = 0;
    {resetn, ring, aa, oo, ext, hs, key, fault, hd, carrier} = '0;
    {demod, rev_rx, rdy, snd, txb, supb} = 6'h03;
    rows[0]  = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0};
    rows[1]  = '{0, 1, 1, 0, 0, 0, 0, 0, 0, 1};
    rows[2]  = '{0, 1, 1, 0, 0, 0, 1, 1, 1, 1};
    rows[3]  = '{1, 1, 1, 0, 0, 0, 1, 0, 1, 1};
    rows[4]  = '{0, 0, 1, 0, 0, 0, 1, 1, 1, 0};
    rows[5]  = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0};
    rows[6]  = '{0, 1, 1, 1, 0, 0, 1, 0, 0, 1};
    rows[7]  = '{0, 0, 1, 1, 1, 0, 1, 1, 1, 0};
    rows[8]  = '{0, 0, 1, 1, 1, 0, 0, 0, 0, 0};
    rows[9]  = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
    rows[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    tick(20);
    chk_rst({dsr, cts, dcd, ri, hook, txc, rd, sb, txd, rtx});
    resetn = 1'h1;
    foreach (rows[i])
    begin
      {fault, ring, aa, oo, ext, hs, rdy} = rows[i][9:3];
      tick(8);
      chk("dsr", rows[i].e_dsr, dsr);
      chk("ri", rows[i].e_ri, ri);
      chk("off_hook", rows[i].e_hook, hook);
    end
    // Data key with ready off must drop the call
    hs = 1'h1;
    tick(6);
    key = 1'h1;
    tick(1);
    chk("hook key", 1'h0, hook);
    chk("dsr key now", 1'h0, dsr);
    key = 1'h0;
    repeat (8)
    begin
      tick(1);
      chk("dsr key", 1'h0, dsr);
    end
    rdy = 1'h1;
    tick(6);
    key = 1'h1;
    tick(1);
    key = 1'h0;
    hs = 1'h0;
    tick(6);
    chk("dsr key", 1'h1, dsr);
    // Carrier gap restarts qualify, then 40 ms and 15 ms guard
    carrier = 1'h1;
    tick(300);
    carrier = 1'h0;
    tick(3);
    carrier = 1'h1;
    tick(380);
    chk("dcd early", 1'h0, dcd);
    tick(40);
    chk("dcd", 1'h1, dcd);
    {demod, rev_rx} = 2'h0;
    tick(2);
    chk("rd", 1'h0, rd);
    chk("sb", 1'h0, sb);
    carrier = 1'h0;
    tick(130);
    chk("dcd guard", 1'h1, dcd);
    tick(40);
    chk("dcd", 1'h0, dcd);
    chk("rd idle", 1'h1, rd);
    // Send request, clear-to-send delay, local carrier in half duplex
    {snd, txb, supb, hd} = 4'h9;
    tick(20);
    chk("cts early", 1'h0, cts);
    tick(50);
    chk("cts", 1'h1, cts);
    chk("tx_data", 1'h0, txd);
    chk("tx_carrier", 1'h1, txc);
    chk("rev_tx", 1'h1, rtx);
    tick(430);
    chk("dcd local", 1'h1, dcd);
    snd = 1'h0;
    tick(6);
    chk("cts", 1'h0, cts);
    chk("tx_data idle", 1'h1, txd);
    chk("rev_tx", 1'h0, rtx);
    hd = 1'h0;
    rdy = 1'h0;
    tick(8);
    chk("off_hook", 1'h0, hook);
    // Second reset in mid-run
    rdy = 1'h1;
    resetn = 1'h0;
    tick(3);
    chk_rst({dsr, cts, dcd, ri, hook, txc, rd, sb, txd, rtx});
    resetn = 1'h1;
    tick(1);
    chk_rst({dsr, cts, dcd, ri, hook, txc, rd, sb, txd, rtx});
    tick(3);
    end_of_test();
  end
endmodule
